//--- bench/card_slot_model.sv
`timescale 1ns/1ps

// Open-drain lines pulled up.
module card_slot_model (
    // Pull-down enables.
    input wire logic [2:0] dev_card_oe_i,
    input wire logic [2:0] dev_host_oe_i,
    input wire logic [2:0] card_pull_i,
    input wire logic [2:0] host_pull_i,
    // Resolved wire levels.
    output logic [2:0] card_wire_o,
    output logic [2:0] host_wire_o
);
    // Low while anyone pulls.
    assign card_wire_o = ~(dev_card_oe_i | card_pull_i);
    assign host_wire_o = ~(dev_host_oe_i | host_pull_i);
endmodule : card_slot_model

//--- bench/smart_card_session_checker.sv
`timescale 1ns/1ps

// Pin-level checks of the session sequencer.
module smart_card_session_checker #(
    parameter int unsigned HALF_T_CYCLES = 1000
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Host pins and monitors.
    input wire smart_card_pkg::host_pins_s host_i,
    input wire smart_card_pkg::monitor_s mon_i,
    // Device outputs.
    input wire logic [2:0] host_line_oe_o,
    input wire logic [2:0] card_line_oe_o,
    input wire logic boost_supply_en_o,
    input wire logic card_supply_en_o,
    input wire logic card_clk_o,
    input wire logic card_rst_o,
    input wire logic card_io_en_o,
    input wire logic fault_irq_oe_o
);
    import smart_card_pkg::*;

    // One cycle short of step spacing: a step two or more cycles early fails.
    localparam int unsigned VCC_LAG = 3 * HALF_T_CYCLES - 1;
    localparam int unsigned BOOST_LAG = 7 * HALF_T_CYCLES - 1;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // Contact enables stay nested: boost, supply, data, reset.
    property p_vcc_in_boost;
        card_supply_en_o |-> boost_supply_en_o;
    endproperty
    a_vcc_in_boost: assert property (p_vcc_in_boost) else $error("supply without boost");
    property p_io_in_vcc;
        card_io_en_o |-> card_supply_en_o;
    endproperty
    a_io_in_vcc: assert property (p_io_in_vcc) else $error("io without supply");
    property p_rst_in_io;
        card_rst_o |-> card_io_en_o;
    endproperty
    a_rst_in_io: assert property (p_rst_in_io) else $error("reset high without data");
    property p_clk_in_io;
        !card_io_en_o |-> !card_clk_o;
    endproperty
    a_clk_in_io: assert property (p_clk_in_io) else $error("clock without io");
    // Timed spacing of supply rise and boost fall.
    property p_vcc_lag;
        $rose(card_supply_en_o) |-> $past(boost_supply_en_o, VCC_LAG);
    endproperty
    a_vcc_lag: assert property (p_vcc_lag) else $error("supply rose too early");
    property p_boost_lag;
        $fell(boost_supply_en_o) |-> !$past(card_supply_en_o, BOOST_LAG);
    endproperty
    a_boost_lag: assert property (p_boost_lag) else $error("boost fell too early");
    // Sleep refuses; no session, quiet lines.
    property p_sleep_refuse;
        !host_i.mode [*8] |=> !$rose(boost_supply_en_o);
    endproperty
    a_sleep_refuse: assert property (p_sleep_refuse) else $error("activation in sleep");
    property p_quiet;
        !boost_supply_en_o |-> card_line_oe_o == 3'h0 && host_line_oe_o == 3'h0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("lines driven idle");
    // Faults raise interrupt, drop reset.
    property p_supply_irq;
        mon_i.supply_low [*8] |-> fault_irq_oe_o;
    endproperty
    a_supply_irq: assert property (p_supply_irq) else $error("supply drop missed");
    property p_fault_rst;
        $rose(fault_irq_oe_o) |-> ##[0:3] !card_rst_o;
    endproperty
    a_fault_rst: assert property (p_fault_rst) else $error("reset kept after fault");
    property p_no_card_irq;
        (fault_irq_oe_o && !mon_i.card_present) [*8] |=> fault_irq_oe_o;
    endproperty
    a_no_card_irq: assert property (p_no_card_irq) else $error("irq freed, no card");

    c_rst: cover property ($rose(card_rst_o));
    c_irq: cover property ($rose(fault_irq_oe_o));
    c_end: cover property ($fell(boost_supply_en_o));
endmodule : smart_card_session_checker

bind smart_card_session_sequencer smart_card_session_checker #(
    .HALF_T_CYCLES(HALF_T_CYCLES)
) u_checker (
    .core_clk_i, .arst_n_i, .host_i, .mon_i, .host_line_oe_o, .card_line_oe_o,
    .boost_supply_en_o, .card_supply_en_o, .card_clk_o, .card_rst_o, .card_io_en_o,
    .fault_irq_oe_o
);

//--- bench/smart_card_session_sequencer_tb.sv
`timescale 1ns/1ps

// Sessions over pins and bus.
module smart_card_session_sequencer_tb;
    import smart_card_pkg::*;

    localparam int HT = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    axi_req_s req = '0;
    axi_rsp_s rsp;
    host_pins_s hp = 7'h62;
    monitor_s mon = 4'h8;
    logic [2:0] card_pull = 3'h0;
    logic [2:0] host_pull = 3'h0;
    logic [2:0] card_w, host_w, card_oe, host_oe;
    logic boost, vcc, io_en, c_clk, c_rst, aux, irq_oe;
    logic [11:0] ev;
    logic [1:0] tv;
    logic [1:0] dsel [3] = '{2'h2, 2'h0, 2'h3};
    int dexp [3] = '{16, 8, 0};
    int errors = 0;
    int n_compared = 0;
    int n, t;
    logic [31:0] rd;
    logic [1:0] code;

    // Free-running core clock, 5 ns period.
    always #2.5 clk = ~clk;

    // Watched events.
    assign ev = {rsp.rvalid, rsp.arready, rsp.bvalid, rsp.awready & rsp.wready,
        card_oe[1], host_oe[0], irq_oe, c_clk, c_rst, io_en, vcc, boost};
    assign tv = {c_clk, aux};

    smart_card_session_sequencer #(
        .HALF_T_CYCLES(HT), .SLEEP_AUX_HALF(8), .NORM_AUX_HALF(2), .WAKE_AUX_CYCLES(96)
    ) DUT (
        .core_clk_i(clk), .arst_n_i(rst_n), .axi_i(req), .axi_o(rsp), .host_i(hp),
        .mon_i(mon), .host_line_i(host_w), .host_line_o(), .host_line_oe_o(host_oe),
        .card_line_i(card_w), .card_line_o(), .card_line_oe_o(card_oe),
        .boost_supply_en_o(boost), .card_supply_en_o(vcc), .card_clk_o(c_clk),
        .card_rst_o(c_rst), .card_io_en_o(io_en), .aux_clock_out_o(aux),
        .fault_irq_n_o(), .fault_irq_oe_o(irq_oe)
    );

    card_slot_model slot (
        .dev_card_oe_i(card_oe), .dev_host_oe_i(host_oe), .card_pull_i(card_pull),
        .host_pull_i(host_pull), .card_wire_o(card_w), .host_wire_o(host_w)
    );

    task automatic close_out();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    // Spacing may slip one cycle.
    function automatic logic [31:0] near(input int v, input int e);
        return 32'(v >= e - 1 && v <= e + 1);
    endfunction : near

    // Bounded wait; edge count in n.
    task automatic wait_ev(input int idx, input logic lvl, input int lim);
        n = 0;
        while (ev[idx] !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin
            errors++;
            close_out();
        end
    endtask : wait_ev

    task automatic toggles(input int idx, input int len);
        logic last;
        t = 0;
        last = tv[idx];
        repeat (len) begin
            @(posedge clk);
            if (tv[idx] !== last) t++;
            last = tv[idx];
        end
    endtask : toggles

    // Write: address and data together, response with bready up.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        @(posedge clk);
        wait_ev(8, 1'b1, 50);
        req.awvalid <= 1'b0;
        req.wvalid <= 1'b0;
        @(posedge clk);
        wait_ev(9, 1'b1, 50);
        code = rsp.bresp;
        req.bready <= 1'b0;
        @(posedge clk);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        @(posedge clk);
        wait_ev(10, 1'b1, 50);
        req.arvalid <= 1'b0;
        @(posedge clk);
        wait_ev(11, 1'b1, 50);
        rd = rsp.rdata;
        code = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge clk);
    endtask : axi_rd

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        // Idle, registers, stopped start.
        chk("idle pins", 32'(ev[7:0]), 32'h0);
        toggles(0, 32);
        chk("aux fast", 32'(t), 32'd16);
        axi_rd(8'h08);
        chk("status", rd, 32'h0009_0001);
        axi_rd(8'h10);
        chk("unmapped", 32'(code), 32'h2);
        axi_rd(8'h04);
        chk("halft", rd, 32'(HT));
        axi_wr(8'h00, 32'h1);
        hp.supply_request_n <= 1'b0;
        repeat (20) @(posedge clk);
        chk("stopped", 32'(boost), 32'h0);
        // Activation steps in order.
        axi_wr(8'h00, 32'h0);
        wait_ev(0, 1'b1, 100);
        wait_ev(1, 1'b1, 100);
        chk("vcc step", near(n, 3 * HT), 32'h1);
        wait_ev(2, 1'b1, 100);
        chk("io step", near(n, 5 * HT), 32'h1);
        chk("clk held", 32'(c_clk), 32'h0);
        hp.host_reset_in <= 1'b1;
        toggles(1, 16);
        chk("clk start", 32'(t > 0), 32'h1);
        repeat (12) @(posedge clk);
        axi_rd(8'h08);
        chk("active", 32'(rd[5:0]), 32'h10);
        hp.host_reset_in <= 1'b0;
        repeat (8) @(posedge clk);
        chk("rst inv", 32'(c_rst), 32'h1);
        // Card clock dividers.
        for (int k = 0; k < 3; k++) begin
            {hp.card_clock_div_sel_a, hp.card_clock_div_sel_b} <= dsel[k];
            repeat (8) @(posedge clk);
            toggles(1, 16);
            chk("clk div", 32'(t), 32'(dexp[k]));
        end
        {hp.card_clock_div_sel_a, hp.card_clock_div_sel_b} <= 2'h2;
        // Data from card, aux a from host.
        card_pull[0] <= 1'b1;
        wait_ev(6, 1'b1, 20);
        card_pull[0] <= 1'b0;
        host_pull[1] <= 1'b1;
        wait_ev(7, 1'b1, 20);
        host_pull[1] <= 1'b0;
        repeat (20) @(posedge clk);
        // Deactivation steps in order.
        hp.supply_request_n <= 1'b1;
        wait_ev(3, 1'b0, 20);
        wait_ev(2, 1'b0, 100);
        chk("io off", near(n, 2 * HT), 32'h1);
        wait_ev(1, 1'b0, 100);
        chk("vcc off", near(n, HT), 32'h1);
        wait_ev(0, 1'b0, 100);
        chk("boost off", near(n, 7 * HT), 32'h1);
        axi_rd(8'h08);
        chk("idle again", rd, 32'h0009_0001);
        // Overcurrent aborts; interrupt waits for request high.
        hp.supply_request_n <= 1'b0;
        wait_ev(1, 1'b1, 100);
        mon.overcurrent <= 1'b1;
        wait_ev(5, 1'b1, 20);
        wait_ev(0, 1'b0, 100);
        chk("abort", near(n, 10 * HT), 32'h1);
        mon.overcurrent <= 1'b0;
        repeat (10) @(posedge clk);
        chk("irq held", 32'(irq_oe), 32'h1);
        axi_rd(8'h0C);
        chk("fault", rd, 32'h1);
        hp.supply_request_n <= 1'b1;
        wait_ev(5, 1'b0, 20);
        axi_wr(8'h0C, 32'h1);
        chk("wr resp", 32'(code), 32'h0);
        axi_rd(8'h0C);
        chk("fault clr", rd, 32'h0);
        // Card pulled keeps the interrupt.
        hp.supply_request_n <= 1'b0;
        wait_ev(1, 1'b1, 100);
        mon.card_present <= 1'b0;
        wait_ev(5, 1'b1, 20);
        hp.supply_request_n <= 1'b1;
        wait_ev(0, 1'b0, 100);
        repeat (10) @(posedge clk);
        chk("no card", 32'(irq_oe), 32'h1);
        mon.card_present <= 1'b1;
        wait_ev(5, 1'b0, 20);
        // Supply drop blocks a start.
        mon.supply_low <= 1'b1;
        hp.supply_request_n <= 1'b0;
        repeat (20) @(posedge clk);
        chk("low supply", 32'({boost, irq_oe}), 32'h1);
        mon.supply_low <= 1'b0;
        hp.supply_request_n <= 1'b1;
        wait_ev(5, 1'b0, 20);
        // Sleep ends session; wake with request low.
        hp.supply_request_n <= 1'b0;
        wait_ev(0, 1'b1, 100);
        repeat (80) @(posedge clk);
        hp.mode <= 1'b0;
        wait_ev(0, 1'b0, 200);
        axi_rd(8'h08);
        chk("sleep", 32'(rd[5:0]), 32'h2);
        toggles(0, 32);
        chk("aux slow", 32'(t), 32'd4);
        chk("refused", 32'(boost), 32'h0);
        hp.mode <= 1'b1;
        wait_ev(0, 1'b1, 3000);
        chk("wake wait", 32'(n > 95 * 16), 32'h1);
        hp.supply_request_n <= 1'b1;
        wait_ev(0, 1'b0, 200);
        close_out();
    end
endmodule : smart_card_session_sequencer_tb

//--- verilog/pin_sync.sv
`timescale 1ns/1ps

// Three-flop sync; a change counts once stages two and three agree.
module pin_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Pins and their filtered values.
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] pin_o
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] val;
    } sync_state_s;

    sync_state_s q;
    sync_state_s d;

    // Stage one feeds only stage two, containing metastability.
    always_comb begin
        d = q;
        d.s1 = pin_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.val = ((q.s2 ~^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.val);
    end

    // State register.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end else begin
            q <= d;
        end
    end

    assign pin_o = q.val;

endmodule : pin_sync

//--- verilog/smart_card_consts.svh
`ifndef SMART_CARD_CONSTS_SVH
`define SMART_CARD_CONSTS_SVH

// Core and aux clock rates.
`define CORE_CLK_HZ 200000000
`define SLEEP_AUX_HZ 16000
`define NORM_AUX_HZ 20000000
`define SLEEP_AUX_HALF ((`CORE_CLK_HZ) / (2 * (`SLEEP_AUX_HZ)))
`define NORM_AUX_HALF ((`CORE_CLK_HZ) / (2 * (`NORM_AUX_HZ)))

// Wake wait in aux cycles; default half-T in core cycles.
`define WAKE_AUX_CYCLES 96
`define HALF_T_DEFAULT 1000

// Step positions in half-T ticks.
`define ACT_POS_VCC 4'h3
`define ACT_POS_IO 4'h8
`define ACT_POS_RST 4'hE
`define DEA_POS_CLK 4'h1
`define DEA_POS_IO 4'h2
`define DEA_POS_VCC 4'h3
`define DEA_POS_BOOST 4'hA

// Register byte offsets.
`define REG_CTRL 8'h00
`define REG_HALFT 8'h04
`define REG_STATUS 8'h08
`define REG_FAULT 8'h0C

// Field positions.
`define CTRL_STOP_BIT 0
`define FLT_OVC_BIT 0
`define FLT_REMOVE_BIT 1
`define FLT_SUPPLY_BIT 2
`define FLT_HEAT_BIT 3

// Reset values.
`define CTRL_RESET 1'h0
`define FAULT_RESET 4'h0
`define SYNC_RESET 17'h1803F

// Bus answers.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- verilog/smart_card_pkg.sv
package smart_card_pkg;

    // Sequencer states, one-hot.
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SLEEP = 6'h02,
        ST_WAKE = 6'h04,
        ST_ACTIVATE = 6'h08,
        ST_ACTIVE = 6'h10,
        ST_DEACT = 6'h20
    } seq_state_e;

    // AXI4-Lite master to slave signals.
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axi_req_s;

    // AXI4-Lite slave to master signals.
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;

    // Control pins driven by the host.
    typedef struct packed {
        logic mode;
        logic supply_request_n;
        logic host_reset_in;
        logic clock_source_sel;
        logic card_clock_div_sel_a;
        logic card_clock_div_sel_b;
        logic strobe;
    } host_pins_s;

    // Monitor inputs from the analog supervisor and the card slot.
    typedef struct packed {
        logic card_present;
        logic overcurrent;
        logic overheat;
        logic supply_low;
    } monitor_s;

    // Whole state of the sequencer.
    typedef struct packed {
        seq_state_e st;
        logic [15:0] halft_cnt;
        logic [3:0] pos;
        logic [15:0] aux_cnt;
        logic aux_clk;
        logic [6:0] wake_cnt;
        logic boost;
        logic vcc;
        logic io_en;
        logic clk_run;
        logic rst_en;
        logic card_rst;
        logic card_clk;
        logic card_div;
        logic [2:0] host_m;
        logic [2:0] card_m;
        logic [2:0] card_oe;
        logic [2:0] host_oe;
        logic [3:0] fault;
        logic irq;
        logic stop;
        logic [15:0] halft_reg;
        axi_rsp_s axi;
    } seq_regs_s;

endpackage : smart_card_pkg

//--- verilog/smart_card_session_sequencer.sv
`timescale 1ns/1ps
`include "smart_card_consts.svh"

module smart_card_session_sequencer #(
    parameter int unsigned HALF_T_CYCLES = `HALF_T_DEFAULT,
    parameter int unsigned SLEEP_AUX_HALF = `SLEEP_AUX_HALF,
    parameter int unsigned NORM_AUX_HALF = `NORM_AUX_HALF,
    parameter int unsigned WAKE_AUX_CYCLES = `WAKE_AUX_CYCLES
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Register bus.
    input wire smart_card_pkg::axi_req_s axi_i,
    output smart_card_pkg::axi_rsp_s axi_o,
    // Host control pins and monitors.
    input wire smart_card_pkg::host_pins_s host_i,
    input wire smart_card_pkg::monitor_s mon_i,
    // Open-drain lines: bit 0 data, 1 aux a, 2 aux b.
    input wire logic [2:0] host_line_i,
    output logic [2:0] host_line_o,
    output logic [2:0] host_line_oe_o,
    input wire logic [2:0] card_line_i,
    output logic [2:0] card_line_o,
    output logic [2:0] card_line_oe_o,
    // Card contacts and supplies.
    output logic boost_supply_en_o,
    output logic card_supply_en_o,
    output logic card_clk_o,
    output logic card_rst_o,
    output logic card_io_en_o,
    // Host side outputs.
    output logic aux_clock_out_o,
    output logic fault_irq_n_o,
    output logic fault_irq_oe_o
);
    import smart_card_pkg::*;

    seq_regs_s q;
    seq_regs_s d;
    logic [16:0] sync_pins;
    host_pins_s hp;
    monitor_s mon;
    logic [2:0] hline;
    logic [2:0] cline;
    logic [15:0] halft_last;
    logic [15:0] aux_last;
    logic tick;
    logic aux_rise;
    logic session;
    logic end_req;
    logic [3:0] fault_ev;
    logic [3:0] fault_w1c;
    logic wr_go;
    logic rd_go;
    logic [31:0] rd_data;
    logic rd_err;
    logic wr_err;

    // All pins cross here.
    pin_sync #(
        .WIDTH(17),
        .RESET_VAL(`SYNC_RESET)
    ) u_pin_sync (
        .core_clk_i,
        .arst_n_i,
        .pin_i({host_i, mon_i, host_line_i, card_line_i}),
        .pin_o(sync_pins)
    );

    // Unpack the filtered pins.
    assign hp = host_pins_s'(sync_pins[16:10]);
    assign mon = monitor_s'(sync_pins[9:6]);
    assign hline = sync_pins[5:3];
    assign cline = sync_pins[2:0];

    // Divider ends; zero half-T acts as one cycle.
    assign halft_last = (q.halft_reg == 16'h0000) ? 16'h0000 : q.halft_reg - 16'h0001;
    assign tick = (q.halft_cnt >= halft_last);
    assign aux_last = (q.st == ST_SLEEP || q.st == ST_WAKE) ?
        16'(SLEEP_AUX_HALF - 1) : 16'(NORM_AUX_HALF - 1);
    assign aux_rise = (q.aux_cnt >= aux_last) && !q.aux_clk;

    // Faults count only during activation and the active session, except supply low, which counts in every state.
    assign session = (q.st == ST_ACTIVATE) || (q.st == ST_ACTIVE);
    assign end_req = hp.supply_request_n || !hp.mode || q.stop;
    assign fault_ev[`FLT_OVC_BIT] = session && mon.overcurrent;
    assign fault_ev[`FLT_REMOVE_BIT] = session && !mon.card_present;
    assign fault_ev[`FLT_SUPPLY_BIT] = mon.supply_low;
    assign fault_ev[`FLT_HEAT_BIT] = session && mon.overheat;

    // Handshake: registered ready meets held valid.
    assign wr_go = q.axi.awready && q.axi.wready && axi_i.awvalid && axi_i.wvalid;
    assign rd_go = q.axi.arready && axi_i.arvalid;

    // Clear mask for fault causes.
    assign fault_w1c = (wr_go && axi_i.awaddr == `REG_FAULT && axi_i.wstrb[0]) ?
        axi_i.wdata[3:0] : 4'h0;

    // Unmapped writes get an error.
    always_comb begin
        if (axi_i.awaddr == `REG_CTRL) begin
            wr_err = 1'b0;
        end else if (axi_i.awaddr == `REG_HALFT) begin
            wr_err = 1'b0;
        end else if (axi_i.awaddr == `REG_STATUS) begin
            wr_err = 1'b0;
        end else if (axi_i.awaddr == `REG_FAULT) begin
            wr_err = 1'b0;
        end else begin
            wr_err = 1'b1;
        end
    end

    // Read decode; unmapped reads give zero and error.
    always_comb begin
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        if (axi_i.araddr == `REG_CTRL) begin
            rd_data[`CTRL_STOP_BIT] = q.stop;
        end else if (axi_i.araddr == `REG_HALFT) begin
            rd_data[15:0] = q.halft_reg;
        end else if (axi_i.araddr == `REG_STATUS) begin
            rd_data[5:0] = q.st;
            rd_data[11:8] = q.pos;
            rd_data[16] = mon.card_present;
            rd_data[17] = q.irq;
            rd_data[18] = mon.supply_low;
            rd_data[19] = hp.mode;
        end else if (axi_i.araddr == `REG_FAULT) begin
            rd_data[3:0] = q.fault;
        end else begin
            rd_err = 1'b1;
        end
    end

    // Next-state logic for the whole block.
    always_comb begin
        d = q;

        // Half-T time base.
        d.halft_cnt = tick ? 16'h0000 : q.halft_cnt + 16'h0001;

        // Aux divider, slow while asleep or waking.
        if (q.aux_cnt >= aux_last) begin
            d.aux_cnt = 16'h0000;
            d.aux_clk = !q.aux_clk;
        end else begin
            d.aux_cnt = q.aux_cnt + 16'h0001;
        end

        // Sequencer.
        case (q.st)
            ST_IDLE: begin
                if (!hp.mode) begin
                    d.st = ST_SLEEP;
                end else if (!hp.supply_request_n && !q.stop && !mon.supply_low && !q.irq) begin
                    d.st = ST_ACTIVATE;
                    d.boost = 1'b1;
                    d.pos = 4'h0;
                    d.halft_cnt = 16'h0000;
                end
            end
            ST_SLEEP: begin
                if (hp.mode) begin
                    d.st = ST_WAKE;
                    d.wake_cnt = 7'h00;
                end
            end
            ST_WAKE: begin
                if (!hp.mode) begin
                    d.st = ST_SLEEP;
                end else if (aux_rise) begin
                    d.wake_cnt = q.wake_cnt + 7'h01;
                    if (q.wake_cnt == 7'(WAKE_AUX_CYCLES - 1)) begin
                        d.st = ST_IDLE;
                    end
                end
            end
            ST_ACTIVATE: begin
                if (end_req || (fault_ev != 4'h0)) begin
                    d.st = ST_DEACT;
                    d.pos = 4'h0;
                    d.halft_cnt = 16'h0000;
                    d.rst_en = 1'b0;
                end else if (tick) begin
                    d.pos = q.pos + 4'h1;
                    if (d.pos == `ACT_POS_VCC) begin
                        d.vcc = 1'b1;
                    end
                    if (d.pos == `ACT_POS_IO) begin
                        d.io_en = 1'b1;
                    end
                    if (d.pos == `ACT_POS_RST) begin
                        d.rst_en = 1'b1;
                        d.clk_run = 1'b1;
                        d.st = ST_ACTIVE;
                    end
                end
                // Host reset starts the clock before reset enable.
                if (q.io_en && !q.rst_en && hp.host_reset_in) begin
                    d.clk_run = 1'b1;
                end
            end
            ST_ACTIVE: begin
                if (end_req || (fault_ev != 4'h0)) begin
                    d.st = ST_DEACT;
                    d.pos = 4'h0;
                    d.halft_cnt = 16'h0000;
                    d.rst_en = 1'b0;
                end
            end
            ST_DEACT: begin
                if (tick) begin
                    d.pos = q.pos + 4'h1;
                    if (d.pos == `DEA_POS_CLK) begin
                        d.clk_run = 1'b0;
                    end
                    if (d.pos == `DEA_POS_IO) begin
                        d.io_en = 1'b0;
                    end
                    if (d.pos == `DEA_POS_VCC) begin
                        d.vcc = 1'b0;
                    end
                    if (d.pos == `DEA_POS_BOOST) begin
                        d.boost = 1'b0;
                        d.pos = 4'h0;
                        d.st = hp.mode ? ST_IDLE : ST_SLEEP;
                    end
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        // Card reset is inverse host reset once enabled.
        d.card_rst = d.rst_en && !hp.host_reset_in;

        // Card clock: strobe, /2, /4 or low.
        d.card_div = !q.card_div;
        if (!d.clk_run || !hp.mode) begin
            d.card_clk = 1'b0;
        end else if (hp.clock_source_sel) begin
            d.card_clk = hp.strobe;
        end else begin
            case ({hp.card_clock_div_sel_a, hp.card_clock_div_sel_b})
                2'b10: d.card_clk = !q.card_clk;
                2'b01: d.card_clk = !q.card_clk;
                2'b00: d.card_clk = q.card_div ? !q.card_clk : q.card_clk;
                default: d.card_clk = 1'b0;
            endcase
        end

        // First side seen low drives the other until high.
        if (q.st == ST_ACTIVE) begin
            d.host_m = q.host_m & ~hline;
            d.card_m = q.card_m & ~cline;
            d.host_m = d.host_m | (~hline & ~q.card_m & ~q.host_m);
            d.card_m = d.card_m | (~cline & ~q.host_m & ~q.card_m & hline);
        end else begin
            d.host_m = 3'h0;
            d.card_m = 3'h0;
        end
        d.card_oe = d.host_m & {3{d.io_en}};
        d.host_oe = d.card_m & {3{d.io_en}};

        // Sticky causes; an event beats a clear.
        d.fault = (q.fault & ~fault_w1c) | fault_ev;

        // Pending interrupt blocks restart; frees in idle with card, request high.
        if (fault_ev != 4'h0) begin
            d.irq = 1'b1;
        end else if (q.st == ST_IDLE && hp.supply_request_n && mon.card_present) begin
            d.irq = 1'b0;
        end

        // Register writes.
        if (wr_go && axi_i.awaddr == `REG_CTRL && axi_i.wstrb[0]) begin
            d.stop = axi_i.wdata[`CTRL_STOP_BIT];
        end
        if (wr_go && axi_i.awaddr == `REG_HALFT) begin
            if (axi_i.wstrb[0]) begin
                d.halft_reg[7:0] = axi_i.wdata[7:0];
            end
            if (axi_i.wstrb[1]) begin
                d.halft_reg[15:8] = axi_i.wdata[15:8];
            end
        end

        // Write ready pulses; response waits for bready.
        d.axi.awready = 1'b0;
        d.axi.wready = 1'b0;
        if (wr_go) begin
            d.axi.bvalid = 1'b1;
            d.axi.bresp = wr_err ? `RESP_SLVERR : `RESP_OKAY;
        end else if (q.axi.bvalid && axi_i.bready) begin
            d.axi.bvalid = 1'b0;
        end else if (!q.axi.bvalid && !q.axi.awready && axi_i.awvalid && axi_i.wvalid) begin
            d.axi.awready = 1'b1;
            d.axi.wready = 1'b1;
        end

        // Read: same scheme, data caught at handshake.
        d.axi.arready = 1'b0;
        if (rd_go) begin
            d.axi.rvalid = 1'b1;
            d.axi.rdata = rd_data;
            d.axi.rresp = rd_err ? `RESP_SLVERR : `RESP_OKAY;
        end else if (q.axi.rvalid && axi_i.rready) begin
            d.axi.rvalid = 1'b0;
        end else if (!q.axi.rvalid && !q.axi.arready && axi_i.arvalid) begin
            d.axi.arready = 1'b1;
        end
    end

    // State register; reset gives idle.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.stop <= `CTRL_RESET;
            q.fault <= `FAULT_RESET;
            q.halft_reg <= 16'(HALF_T_CYCLES);
        end else begin
            q <= d;
        end
    end

    // Outputs from flops; open-drain lines only pull low.
    assign axi_o = q.axi;
    assign host_line_o = 3'h0;
    assign host_line_oe_o = q.host_oe;
    assign card_line_o = 3'h0;
    assign card_line_oe_o = q.card_oe;
    assign boost_supply_en_o = q.boost;
    assign card_supply_en_o = q.vcc;
    assign card_clk_o = q.card_clk;
    assign card_rst_o = q.card_rst;
    assign card_io_en_o = q.io_en;
    assign aux_clock_out_o = q.aux_clk;
    assign fault_irq_n_o = 1'b0;
    assign fault_irq_oe_o = q.irq;

endmodule : smart_card_session_sequencer
